// ===== src/fwsr_pkg.sv
package fwsr_pkg;

    // clock and timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int T_ACC_NS = 70;
    localparam int T_WP_NS = 35;
    localparam int T_GAP_NS = 40;
    localparam int SYNC_STAGES = 3;
    localparam int T_ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_GAP_CYC = (T_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // sampling waits for the three-stage pipeline and the agree stage
    localparam int RD_WAIT_CYC = T_ACC_CYC + SYNC_STAGES + 1;

    // flash pins and data
    localparam int ADDR_W = 19;
    localparam int DQ_W = 8;
    localparam logic [DQ_W-1:0] RESET_CMD_DATA = 8'hF0;

    // status bit positions on the flash data lines
    localparam int DQ_POLL = 7;
    localparam int DQ_TOG = 6;
    localparam int DQ_TMO = 5;
    localparam int DQ_ESTART = 3;
    localparam int DQ_STOG = 2;

    // register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_DATA = 8'h0C;

    // control fields (write-only pulses)
    localparam int CTRL_START = 0;
    localparam int CTRL_RSTCMD = 1;
    localparam int CTRL_ABORT = 2;

    // status fields
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_FAIL = 2;
    localparam int ST_SUSP = 3;
    localparam int ST_READY = 4;
    localparam int ST_ESTART = 5;
    localparam int ST_RSTSENT = 6;

    // reset values
    localparam logic [ADDR_W-1:0] ADDR_RESET = 19'h00000;

    // axi answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic ceN;
        logic oeN;
        logic weN;
        logic [ADDR_W-1:0] addr;
        logic [DQ_W-1:0] dqOut;
        logic dqOe;
    } fwsrPins_s;

endpackage : fwsr_pkg

// ===== src/fwsr_cycle.sv
`timescale 1ns/10ps
module fwsr_cycle
    import fwsr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // cycle request
    input wire logic req,
    input wire logic wr,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DQ_W-1:0] wdata,
    output logic idle,
    output logic done,
    output logic [DQ_W-1:0] rdata,
    // flash pins
    output fwsrPins_s pins,
    input wire logic [DQ_W-1:0] dqIn
);

    typedef enum logic [3:0] {
        C_IDLE = 4'h1,
        C_RD = 4'h2,
        C_WR = 4'h4,
        C_GAP = 4'h8
    } fwsrCyc_e;

    fwsrCyc_e state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic done_q, done_d;
    logic [DQ_W-1:0] rdata_q, rdata_d;
    fwsrPins_s pins_q, pins_d;
    logic [DQ_W-1:0] s1_q, s2_q, s3_q, stable_q, stable_d;

    // a level counts only once stages two and three agree
    always_comb begin
        stable_d = (s2_q == s3_q) ? s3_q : stable_q;
    end

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        done_d = 1'b0;
        rdata_d = rdata_q;
        pins_d = pins_q;
        case (state_q)
            C_IDLE: begin
                if (req) begin
                    pins_d.addr = addr;
                    pins_d.ceN = 1'b0;
                    pins_d.dqOut = wdata;
                    cnt_d = 4'h0;
                    if (wr) begin
                        pins_d.weN = 1'b0;
                        pins_d.dqOe = 1'b1;
                        state_d = C_WR;
                    end else begin
                        pins_d.oeN = 1'b0;
                        state_d = C_RD;
                    end
                end
            end
            C_RD: begin
                cnt_d = cnt_q + 4'h1;
                if (cnt_q == 4'(RD_WAIT_CYC - 1)) begin
                    rdata_d = stable_q;
                    done_d = 1'b1;
                    // releasing both strobes ends one read cycle
                    pins_d.oeN = 1'b1;
                    pins_d.ceN = 1'b1;
                    cnt_d = 4'h0;
                    state_d = C_GAP;
                end
            end
            C_WR: begin
                cnt_d = cnt_q + 4'h1;
                if (cnt_q == 4'(T_WP_CYC - 1)) begin
                    done_d = 1'b1;
                    pins_d.weN = 1'b1;
                    pins_d.ceN = 1'b1;
                    cnt_d = 4'h0;
                    state_d = C_GAP;
                end
            end
            C_GAP: begin
                cnt_d = cnt_q + 4'h1;
                if (cnt_q == 4'(T_GAP_CYC - 1)) begin
                    pins_d.dqOe = 1'b0;
                    state_d = C_IDLE;
                end
            end
            default: begin
                state_d = C_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= C_IDLE;
            cnt_q <= 4'h0;
            done_q <= 1'b0;
            rdata_q <= 8'h00;
            pins_q <= '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1, addr: ADDR_RESET, dqOut: 8'h00, dqOe: 1'b0};
            s1_q <= 8'h00;
            s2_q <= 8'h00;
            s3_q <= 8'h00;
            stable_q <= 8'h00;
        end else if (ce) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            done_q <= done_d;
            rdata_q <= rdata_d;
            pins_q <= pins_d;
            s1_q <= dqIn;
            s2_q <= s1_q;
            s3_q <= s2_q;
            stable_q <= stable_d;
        end
    end

    assign idle = (state_q == C_IDLE);
    assign done = done_q;
    assign rdata = rdata_q;
    assign pins = pins_q;

endmodule : fwsr_cycle

// ===== src/fwsr_host.sv
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
// Function
// - after a failure the host writes the reset command.
// - on failure bit high the host checks the toggle bit again.
// - host combines sector toggle and toggle bit to spot erase suspend.
// - host reads at least twice and compares the toggle bit values.
// - toggling with failure bit high: recheck, still toggling means failed.
// - host returning to polling restarts the algorithm from its first step.
// - host reads status at a valid address inside the affected sector.
module fwsr_host
    import fwsr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // axi4-lite slave
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // flash pins
    output fwsrPins_s flashPins,
    input wire logic [DQ_W-1:0] dqIn,
    input wire logic readyBusyIn
);
    typedef enum logic [5:0] {P_IDLE = 6'h01, P_READ1 = 6'h02, P_READ2 = 6'h04, P_READ3 = 6'h08,
        P_READ4 = 6'h10, P_RSTCMD = 6'h20} fwsrPoll_e;
    function automatic logic regHit(input logic [7:0] a);
        regHit = (a == REG_CTRL) || (a == REG_ADDR) || (a == REG_STATUS) || (a == REG_DATA);
    endfunction : regHit
    // register bus state
    logic awHave_q, awHave_d, wHave_q, wHave_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [7:0] awAddr_q, awAddr_d;
    logic [31:0] wData_q, wData_d, rdata_q, rdata_d;
    logic [3:0] wStrb_q, wStrb_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [ADDR_W-1:0] pollAddr_q, pollAddr_d;
    logic startCmd, rstCmd, abortCmd, doWrite, stClear;
    logic [31:0] statusWord;
    // poll state
    fwsrPoll_e state_q, state_d;
    logic [DQ_W-1:0] first_q, first_d, last_q, last_d;
    logic done_q, done_d, fail_q, fail_d, susp_q, susp_d, rstSent_q, rstSent_d;
    logic setDone, setFail, setRst, abortPend_q, abortPend_d;
    // ready/busy pin synchroniser
    logic rb1_q, rb2_q, rb3_q, rbLevel_q, rbLevel_d;
    // cycle engine link
    logic cycReq, cycWr, cycIdle, cycDone;
    logic [DQ_W-1:0] cycData;
    assign doWrite = awHave_q && wHave_q && !bvalid_q;
    assign startCmd = doWrite && (awAddr_q == REG_CTRL) && wStrb_q[0] && wData_q[CTRL_START];
    assign rstCmd = doWrite && (awAddr_q == REG_CTRL) && wStrb_q[0] && wData_q[CTRL_RSTCMD];
    assign abortCmd = doWrite && (awAddr_q == REG_CTRL) && wStrb_q[0] && wData_q[CTRL_ABORT];
    assign stClear = doWrite && (awAddr_q == REG_STATUS) && wStrb_q[0];
    always_comb begin
        statusWord = 32'h00000000;
        statusWord[ST_BUSY] = (state_q != P_IDLE);
        statusWord[ST_DONE] = done_q;
        statusWord[ST_FAIL] = fail_q;
        statusWord[ST_SUSP] = susp_q;
        statusWord[ST_READY] = rbLevel_q;
        statusWord[ST_ESTART] = last_q[DQ_ESTART];
        statusWord[ST_RSTSENT] = rstSent_q;
    end
    always_comb begin
        awHave_d = awHave_q;
        awAddr_d = awAddr_q;
        wHave_d = wHave_q;
        wData_d = wData_q;
        wStrb_d = wStrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        pollAddr_d = pollAddr_q;
        if (awvalid && awready) begin
            awHave_d = 1'b1;
            awAddr_d = awaddr;
        end
        if (wvalid && wready) begin
            wHave_d = 1'b1;
            wData_d = wdata;
            wStrb_d = wstrb;
        end
        if (bvalid_q && bready) begin
            bvalid_d = 1'b0;
        end
        if (doWrite) begin
            awHave_d = 1'b0;
            wHave_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = regHit(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
            if (awAddr_q == REG_ADDR) begin
                pollAddr_d[7:0] = wStrb_q[0] ? wData_q[7:0] : pollAddr_q[7:0];
                pollAddr_d[15:8] = wStrb_q[1] ? wData_q[15:8] : pollAddr_q[15:8];
                pollAddr_d[ADDR_W-1:16] = wStrb_q[2] ? wData_q[18:16] : pollAddr_q[ADDR_W-1:16];
            end
        end
    end
    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (rvalid_q && rready) begin
            rvalid_d = 1'b0;
        end
        if (arvalid && arready) begin
            rvalid_d = 1'b1;
            rresp_d = regHit(araddr) ? RESP_OKAY : RESP_SLVERR;
            case (araddr)
                REG_ADDR: rdata_d = {13'h0000, pollAddr_q};
                REG_STATUS: rdata_d = statusWord;
                REG_DATA: rdata_d = {24'h000000, last_q};
                default: rdata_d = 32'h00000000;
            endcase
        end
    end
    // toggle-bit polling walk
    always_comb begin
        state_d = state_q;
        first_d = first_q;
        last_d = last_q;
        setDone = 1'b0;
        setFail = 1'b0;
        setRst = 1'b0;
        susp_d = susp_q;
        cycReq = 1'b0;
        cycWr = 1'b0;
        if (cycDone) begin
            last_d = cycData;
        end
        case (state_q)
            P_IDLE: begin
                if (startCmd) begin
                    susp_d = 1'b0;
                    state_d = P_READ1;
                end else if (rstCmd) begin
                    state_d = P_RSTCMD;
                end
            end
            P_READ1, P_READ3: begin
                cycReq = cycIdle;
                if (cycDone) begin
                    first_d = cycData;
                    state_d = (state_q == P_READ1) ? P_READ2 : P_READ4;
                end
            end
            P_READ2: begin
                cycReq = cycIdle;
                if (cycDone) begin
                    if (cycData[DQ_TOG] == first_q[DQ_TOG]) begin
                        setDone = 1'b1;
                        // steady toggle but moving sector toggle means suspended
                        susp_d = (cycData[DQ_STOG] != first_q[DQ_STOG]);
                        state_d = P_IDLE;
                    end else if (cycData[DQ_TMO]) begin
                        state_d = P_READ3;
                    end else begin
                        state_d = P_READ1;
                    end
                end
            end
            P_READ4: begin
                cycReq = cycIdle;
                if (cycDone) begin
                    if (cycData[DQ_TOG] == first_q[DQ_TOG]) begin
                        setDone = 1'b1;
                        susp_d = 1'b0;
                        state_d = P_IDLE;
                    end else begin
                        setFail = 1'b1;
                        state_d = P_RSTCMD;
                    end
                end
            end
            P_RSTCMD: begin
                cycReq = cycIdle;
                cycWr = 1'b1;
                if (cycDone) begin
                    setRst = 1'b1;
                    state_d = P_IDLE;
                end
            end
            default: begin
                state_d = P_IDLE;
            end
        endcase
        // a held abort waits for an idle engine so no stale read feeds a later start
        if ((abortCmd || abortPend_q) && cycIdle && state_q != P_RSTCMD) begin
            state_d = P_IDLE;
            cycReq = 1'b0;
        end
    end
    // the hardware set wins over a software clear
    always_comb begin
        done_d = setDone | (done_q & ~(stClear & wData_q[ST_DONE]));
        fail_d = setFail | (fail_q & ~(stClear & wData_q[ST_FAIL]));
        rstSent_d = setRst | (rstSent_q & ~(stClear & wData_q[ST_RSTSENT]));
        abortPend_d = (abortCmd || abortPend_q) && !cycIdle && state_q != P_IDLE && state_q != P_RSTCMD;
        rbLevel_d = (rb2_q == rb3_q) ? rb3_q : rbLevel_q;
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            awHave_q <= 1'b0;
            awAddr_q <= 8'h00;
            wHave_q <= 1'b0;
            wData_q <= 32'h00000000;
            wStrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= RESP_OKAY;
            pollAddr_q <= ADDR_RESET;
            state_q <= P_IDLE;
            first_q <= 8'h00;
            last_q <= 8'h00;
            done_q <= 1'b0;
            fail_q <= 1'b0;
            susp_q <= 1'b0;
            rstSent_q <= 1'b0;
            abortPend_q <= 1'b0;
            rb1_q <= 1'b1;
            rb2_q <= 1'b1;
            rb3_q <= 1'b1;
            rbLevel_q <= 1'b1;
        end else if (ce) begin
            awHave_q <= awHave_d;
            awAddr_q <= awAddr_d;
            wHave_q <= wHave_d;
            wData_q <= wData_d;
            wStrb_q <= wStrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            pollAddr_q <= pollAddr_d;
            state_q <= state_d;
            first_q <= first_d;
            last_q <= last_d;
            done_q <= done_d;
            fail_q <= fail_d;
            susp_q <= susp_d;
            rstSent_q <= rstSent_d;
            abortPend_q <= abortPend_d;
            rb1_q <= readyBusyIn;
            rb2_q <= rb1_q;
            rb3_q <= rb2_q;
            rbLevel_q <= rbLevel_d;
        end
    end
    fwsr_cycle u_cycle (.clk(clk), .rst(rst), .ce(ce), .req(cycReq), .wr(cycWr), .addr(pollAddr_q),
        .wdata(RESET_CMD_DATA), .idle(cycIdle), .done(cycDone), .rdata(cycData), .pins(flashPins), .dqIn(dqIn));
    assign awready = ce && !awHave_q;
    assign wready = ce && !wHave_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = ce && !rvalid_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

endmodule : fwsr_host

// ===== tb/fwsr_host_sva.sv
`timescale 1ns/10ps
module fwsr_host_sva
    import fwsr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register bus
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    // flash pins
    input wire fwsrPins_s flashPins
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    wire ceN = flashPins.ceN;
    wire oeN = flashPins.oeN;
    wire weN = flashPins.weN;
    wire dqOe = flashPins.dqOe;

    read_len_a: assert property ($fell(oeN) |-> (!oeN && !ceN)[*8] ##1 oeN)
        else $error("read strobe length wrong");
    read_gap_a: assert property ($rose(oeN) |-> oeN[*2])
        else $error("gap between reads too short");
    strobe_excl_a: assert property (!weN |-> oeN)
        else $error("read and write strobes low together");
    cmd_write_a: assert property ($fell(weN) |-> (!weN && dqOe && flashPins.dqOut == RESET_CMD_DATA)[*2] ##1 weN)
        else $error("reset command write malformed");
    data_hold_a: assert property ($rose(weN) |-> dqOe ##1 dqOe)
        else $error("write data released too early");
    no_clash_a: assert property (!oeN |-> !dqOe)
        else $error("host drives data during a read");
    addr_stable_a: assert property (!ceN && !$fell(ceN) |-> $stable(flashPins.addr))
        else $error("address moved inside a cycle");
    read_answer_a: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data not held");
    bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response not held");

    read_seen_c: cover property ($fell(oeN));
    cmd_seen_c: cover property ($fell(weN));
    err_seen_c: cover property (bvalid && bresp == RESP_SLVERR);
endmodule : fwsr_host_sva

bind fwsr_host fwsr_host_sva chk (.clk(clk), .rst(rst), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .bvalid(bvalid), .bready(bready), .bresp(bresp), .flashPins(flashPins));

// ===== tb/fwsr_flash_model.sv
`timescale 1ns/10ps
module fwsr_flash_model
    import fwsr_pkg::*;
(
    // host pins
    input wire fwsrPins_s pins,
    output logic [DQ_W-1:0] dq,
    output logic readyBusy,
    // scenario control
    input wire logic go,
    input wire logic [7:0] busyReads,
    input wire logic failMode,
    input wire logic eraseMode,
    input wire logic suspend,
    // observation
    output logic [31:0] nReads,
    output logic [31:0] nResets,
    output logic [ADDR_W-1:0] cmdAddr
);
    logic [7:0] left = 8'h00;
    logic tog = 1'b0;
    logic stog = 1'b0;
    logic fail = 1'b0;
    logic [DQ_W-1:0] stat;
    wire rdAct = !pins.ceN && !pins.oeN;

    initial begin
        nReads = 32'h0;
        nResets = 32'h0;
        cmdAddr = '0;
    end
    // FF keeps the operation running until a reset command
    always @(posedge go) begin
        left = busyReads;
        fail = failMode;
    end
    // one toggle per read cycle, steady once finished
    always @(posedge rdAct) begin
        nReads = nReads + 1;
        if (left != 8'h00) tog = ~tog;
        if (left != 8'h00 && left != 8'hFF) left = left - 1;
        if (suspend) stog = ~stog;
    end
    always @(posedge pins.weN) begin
        // a started sector erase ignores all but suspend unless it has failed
        if (pins.dqOe && pins.dqOut == RESET_CMD_DATA && !(eraseMode && !fail)) begin
            nResets = nResets + 1;
            cmdAddr = pins.addr;
            left = 8'h00;
            fail = 1'b0;
        end
    end
    assign stat = {(left == 8'h00) || suspend, tog, fail, 1'b0, eraseMode, stog, 2'b00};
    // deselected lines show the inverse so a stale sample never matches
    assign dq = rdAct ? stat : ~stat;
    assign readyBusy = (left == 8'h00) || suspend;
endmodule : fwsr_flash_model

// ===== tb/tb_top.sv
`timescale 1ns/10ps
module tb_top
    import fwsr_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, busyReads = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic go = 1'b0, failMode = 1'b0, eraseMode = 1'b0, suspend = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid, readyBusy;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, nReads, nResets, base, val;
    logic [DQ_W-1:0] dq;
    logic [ADDR_W-1:0] cmdAddr;
    fwsrPins_s flashPins;
    int nMismatch = 0;
    int checksDone = 0;

    always #10 clk = ~clk;

    fwsr_host DUT (.clk(clk), .rst(rst), .ce(1'b1), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .flashPins(flashPins), .dqIn(dq), .readyBusyIn(readyBusy));
    fwsr_flash_model flash (.pins(flashPins), .dq(dq), .readyBusy(readyBusy), .go(go), .busyReads(busyReads),
        .failMode(failMode), .eraseMode(eraseMode), .suspend(suspend), .nReads(nReads), .nResets(nResets),
        .cmdAddr(cmdAddr));

    task automatic test_done;
        $display("checks %0d mismatches %0d", checksDone, nMismatch);
        if (nMismatch == 0 && checksDone > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            nMismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic guard(input int n);
        if (n > 200) begin
            nMismatch++;
            $display("wait ran out at %0t", $time);
            test_done();
        end
    endtask : guard

    // signals sampled at the falling edge hold until the next rising edge
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        logic aw, w, b;
        n = 0;
        b = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b) begin
            @(negedge clk);
            aw = awvalid && awready;
            w = wvalid && wready;
            b = bvalid && bready;
            resp = bresp;
            @(posedge clk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            n++;
            guard(n);
        end
        bready <= 1'b0;
        // one edge between calls so a following call never re-drives a strobe in this step
        @(posedge clk);
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a);
        int n;
        logic ar, r;
        n = 0;
        r = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r) begin
            @(negedge clk);
            ar = arvalid && arready;
            r = rvalid && rready;
            val = rdata;
            resp = rresp;
            @(posedge clk);
            if (ar) arvalid <= 1'b0;
            n++;
            guard(n);
        end
        rready <= 1'b0;
        @(posedge clk);
    endtask : axi_rd

    task automatic wait_idle;
        int n;
        n = 0;
        val = 32'h1;
        while (val[ST_BUSY] !== 1'b0) begin
            axi_rd(REG_STATUS);
            n++;
            guard(n);
        end
        repeat (6) @(posedge clk);
    endtask : wait_idle

    task automatic arm(input logic [7:0] b, input logic f, input logic e, input logic s);
        busyReads <= b;
        failMode <= f;
        eraseMode <= e;
        suspend <= s;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        base = nReads;
    endtask : arm

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        axi_rd(REG_STATUS);
        check(val, 32'h10);
        axi_rd(8'h10);
        check({30'h0, resp}, {30'h0, RESP_SLVERR});
        axi_wr(8'h20, 32'hFF);
        check({30'h0, resp}, {30'h0, RESP_SLVERR});
        axi_wr(REG_ADDR, 32'hFFF92345);
        axi_rd(REG_ADDR);
        check(val, 32'h12345);
        $display("test registers done");
        arm(8'h03, 1'b0, 1'b0, 1'b0);
        repeat (10) @(posedge clk);
        axi_rd(REG_STATUS);
        check(val, 32'h00);
        axi_wr(REG_CTRL, 32'h1);
        wait_idle();
        axi_rd(REG_STATUS);
        check(val, 32'h12);
        check(nReads - base, 32'h4);
        axi_rd(REG_DATA);
        check(val, 32'hC0);
        axi_wr(REG_STATUS, 32'h2);
        $display("test program poll done");
        arm(8'hFF, 1'b0, 1'b0, 1'b0);
        axi_wr(REG_CTRL, 32'h1);
        repeat (30) @(posedge clk);
        axi_wr(REG_CTRL, 32'h4);
        wait_idle();
        axi_rd(REG_STATUS);
        check(val, 32'h00);
        arm(8'h00, 1'b0, 1'b0, 1'b0);
        axi_wr(REG_CTRL, 32'h1);
        wait_idle();
        axi_rd(REG_STATUS);
        check(val, 32'h12);
        check(nReads - base, 32'h2);
        axi_wr(REG_STATUS, 32'h2);
        $display("test abort restart done");
        arm(8'hFF, 1'b1, 1'b1, 1'b0);
        axi_wr(REG_CTRL, 32'h1);
        wait_idle();
        axi_rd(REG_STATUS);
        check(val, 32'h74);
        check(nReads - base, 32'h4);
        check(nResets, 32'h1);
        check({13'h0, cmdAddr}, 32'h12345);
        axi_wr(REG_STATUS, 32'h44);
        axi_rd(REG_STATUS);
        check(val, 32'h30);
        $display("test failure done");
        arm(8'hFF, 1'b0, 1'b0, 1'b0);
        axi_wr(REG_CTRL, 32'h1);
        repeat (15) @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        wait_idle();
        axi_rd(REG_STATUS);
        check(val, 32'h00);
        $display("test mid-run reset done");
        arm(8'h00, 1'b0, 1'b1, 1'b1);
        axi_wr(REG_CTRL, 32'h1);
        wait_idle();
        axi_rd(REG_STATUS);
        check(val, 32'h3A);
        check(nReads - base, 32'h2);
        $display("test suspend done");
        test_done();
    end
endmodule : tb_top
